// >>> logic/nie_regs.vh
// Register offsets, field positions and reset values of the enable bank
`ifndef NIE_REGS_VH
`define NIE_REGS_VH

// Enable set register, 16 bits, printed offset is a byte address
`define NIE_SET_OFFSET      8'h0E
`define NIE_SET_RESET       16'h0000
`define NIE_SET_MASK        16'h07FF
// Clear register and flag register (not printed)
`define NIE_CLR_OFFSET      8'h0C
`define NIE_FLAG_OFFSET     8'h10
// Protection control register (not printed)
`define NIE_PROT_OFFSET     8'h14
`define NIE_NUM_EVENTS      11

// Field positions
`define NIE_BIT_DONE        0
`define NIE_BIT_ADDRESS     1
`define NIE_BIT_PROGRAM     2
`define NIE_BIT_LOCK        3
`define NIE_BIT_ECC_SINGLE  4
`define NIE_BIT_ECC_DUAL    5
`define NIE_BIT_MEM_ERR     6
`define NIE_BIT_SUSPENDED   7
`define NIE_BIT_SEE_FULL    8
`define NIE_BIT_SEE_OVF     9
`define NIE_BIT_SEE_WRC     10

// AXI responses
`define NIE_RESP_OKAY       2'h0
`define NIE_RESP_SLVERR     2'h2

`endif

// >>> logic/nie_lane_merge.v
// Byte-lane merge of a 16-bit half-word register
`timescale 1ns/1ps
`default_nettype none

module nie_lane_merge #(
	parameter W = 16
) (
	input  wire [W-1:0]   old_val,
	input  wire [W-1:0]   new_val,
	input  wire [W/8-1:0] strb,
	output wire [W-1:0]   merged
);

	genvar i;
	generate
		for (i = 0; i < W/8; i = i + 1) begin : g_lane
			assign merged[i*8 +: 8] = strb[i] ? new_val[i*8 +: 8] :
				old_val[i*8 +: 8];
		end
	endgenerate

endmodule

`default_nettype wire

// >>> logic/nie_enable_bank.v
// Interrupt enable bank of the flash controller with an AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "nie_regs.vh"

module nie_enable_bank #(
	parameter N = `NIE_NUM_EVENTS
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        prot_lock_in,
	input  wire [N-1:0] event_pulse,
	output wire [N-1:0] irq_enable,
	output reg         irq
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	reg  [15:0]  enable_ff;
	reg  [15:0]  flag_ff;
	reg          prot_ff;
	reg  [7:0]   awaddr_ff;
	reg  [31:0]  wdata_ff;
	reg  [3:0]   wstrb_ff;
	reg          aw_have_ff;
	reg          w_have_ff;

	wire         protected_now;
	wire [15:0]  mask;
	wire [15:0]  wr_half;
	wire [1:0]   wr_strb;
	wire [15:0]  set_vec;
	wire [15:0]  wr_merged;
	wire         do_write;

	assign mask          = `NIE_SET_MASK;
	assign protected_now = prot_ff | prot_lock_in;
	assign irq_enable    = enable_ff[N-1:0];

	// 32-bit word address holding a 16-bit register at either half
	function [7:0] word_of;
		input [7:0] a;
		begin
			word_of = {a[7:2], 2'b00};
		end
	endfunction

	function hit;
		input [7:0] a;
		input [7:0] reg_off;
		begin
			hit = (word_of(a) == word_of(reg_off));
		end
	endfunction

	// ------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------
	assign s_axi_awready = ~aw_have_ff & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_have_ff & ~s_axi_bvalid;
	assign do_write      = aw_have_ff & w_have_ff & ~s_axi_bvalid;

	// Half select follows bit 1 of the register offset
	assign wr_half = (awaddr_ff[1]) ? wdata_ff[31:16] : wdata_ff[15:0];
	assign wr_strb = (awaddr_ff[1]) ? wstrb_ff[3:2] : wstrb_ff[1:0];

	nie_lane_merge #(
		.W (16)
	) u_merge (
		.old_val (16'h0000),
		.new_val (wr_half),
		.strb    (wr_strb),
		.merged  (wr_merged)
	);

	assign set_vec = wr_merged & mask;

	function reg_half_ok;
		input [7:0] a;
		input [7:0] reg_off;
		begin
			reg_half_ok = hit(a, reg_off) && (a[1] == reg_off[1]);
		end
	endfunction

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff   <= 1'b0;
			w_have_ff    <= 1'b0;
			awaddr_ff    <= 8'h00;
			wdata_ff     <= 32'h0000_0000;
			wstrb_ff     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `NIE_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_ff   <= 1'b0;
				w_have_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (reg_half_ok(awaddr_ff, `NIE_SET_OFFSET) ||
					reg_half_ok(awaddr_ff, `NIE_CLR_OFFSET) ||
					reg_half_ok(awaddr_ff, `NIE_FLAG_OFFSET) ||
					reg_half_ok(awaddr_ff, `NIE_PROT_OFFSET))
					s_axi_bresp <= `NIE_RESP_OKAY;
				else
					s_axi_bresp <= `NIE_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Enable, flag and protection registers
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			enable_ff <= `NIE_SET_RESET;
			prot_ff   <= 1'b0;
		end else if (do_write && !protected_now) begin
			if (reg_half_ok(awaddr_ff, `NIE_SET_OFFSET))
				enable_ff <= enable_ff | set_vec;
			else if (reg_half_ok(awaddr_ff, `NIE_CLR_OFFSET))
				enable_ff <= enable_ff & ~set_vec;
			else if (reg_half_ok(awaddr_ff, `NIE_PROT_OFFSET) && wr_strb[0])
				prot_ff <= wr_half[0];
		end
	end

	// Event set wins over a software clear in the same cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			flag_ff <= 16'h0000;
		end else if (do_write &&
			reg_half_ok(awaddr_ff, `NIE_FLAG_OFFSET)) begin
			flag_ff <= ((flag_ff & ~set_vec) |
				{{(16-N){1'b0}}, event_pulse}) & mask;
		end else begin
			flag_ff <= (flag_ff | {{(16-N){1'b0}}, event_pulse}) & mask;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(flag_ff & enable_ff);
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	reg [15:0] rd_half;
	reg        rd_ok;

	assign s_axi_arready = ~s_axi_rvalid;

	always @* begin
		rd_half = 16'h0000;
		rd_ok   = 1'b1;
		if (reg_half_ok(s_axi_araddr, `NIE_SET_OFFSET) ||
			reg_half_ok(s_axi_araddr, `NIE_CLR_OFFSET))
			rd_half = enable_ff & mask;
		else if (reg_half_ok(s_axi_araddr, `NIE_FLAG_OFFSET))
			rd_half = flag_ff;
		else if (reg_half_ok(s_axi_araddr, `NIE_PROT_OFFSET))
			rd_half = {15'h0000, protected_now};
		else
			rd_ok = 1'b0;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `NIE_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= s_axi_araddr[1] ? {rd_half, 16'h0000} :
				{16'h0000, rd_half};
			s_axi_rresp  <= rd_ok ? `NIE_RESP_OKAY : `NIE_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// >>> bench/nie_props.sv
// Port checker for the enable bank
`timescale 1ns/1ps
`default_nettype none
module nie_props #(parameter N = 11) (
	input wire logic         aclk,
	input wire logic         aresetn,
	input wire logic         s_axi_bvalid,
	input wire logic         s_axi_arvalid,
	input wire logic         s_axi_arready,
	input wire logic         s_axi_rvalid,
	input wire logic         s_axi_rready,
	input wire logic         prot_lock_in,
	input wire logic [N-1:0] event_pulse,
	input wire logic [N-1:0] irq_enable,
	input wire logic         irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rst; $rose(aresetn) |-> irq_enable == '0; endproperty
	a_rst: assert property (p_rst) else $error("reset value");
	property p_chg; !$stable(irq_enable) |-> $rose(s_axi_bvalid); endproperty
	a_chg: assert property (p_chg) else $error("enable moved");
	property p_lck;
		prot_lock_in && $past(prot_lock_in) |-> $stable(irq_enable);
	endproperty
	a_lck: assert property (p_lck) else $error("locked write");
	property p_ion; |(event_pulse & irq_enable) |-> ##[1:3] irq; endproperty
	a_ion: assert property (p_ion) else $error("irq missing");
	property p_iof; (irq_enable == '0) [*2] |-> !irq; endproperty
	a_iof: assert property (p_iof) else $error("stray irq");
	property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_ar: assert property (p_ar) else $error("no answer");
	property p_ard;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_ard: assert property (p_ard) else $error("read overlap");
	property p_rv; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid); endproperty
	a_rv: assert property (p_rv) else $error("stray answer");
endmodule
bind nie_enable_bank nie_props #(.N(N)) u_props (.*);
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the enable bank
`timescale 1ns/1ps
`default_nettype none
`include "nie_regs.vh"
module tb_top;
	logic        aclk = 0, aresetn = 0, prot_lock_in = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic        s_axi_bready = 1, s_axi_rready = 1;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rd_data;
	logic [3:0]  s_axi_wstrb = 0;
	logic [10:0] event_pulse = 0;
	logic [1:0]  rsp;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, irq;
	wire         s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire  [10:0] irq_enable;
	int          n_fail = 0, samples_checked = 0;
	nie_enable_bank uut (.*);
	always #50 aclk = ~aclk;
	task chk(input [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [3:0] s);
		logic aw_done, w_done;
		aw_done = 0;
		w_done = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		rsp = s_axi_bresp;
	endtask
	task rd(input [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd_data = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task t_reset;
		rd(`NIE_SET_OFFSET);
		chk(rd_data[31:16], `NIE_SET_RESET);
	endtask
	task t_set;
		wr(`NIE_SET_OFFSET, 32'h0400_0000, 4'hC);
		wr(`NIE_SET_OFFSET, 32'h0, 4'hC);
		chk(irq_enable, 32'h400);
		wr(`NIE_SET_OFFSET, 32'hFFFF_FFFF, 4'h4);
		chk(irq_enable, 32'h4FF);
		event_pulse <= 11'h001;
		repeat (3) @(posedge aclk);
		event_pulse <= 11'h000;
		chk(irq, 1'h1);
	endtask
	task t_prot;
		prot_lock_in <= 1;
		@(posedge aclk);
		wr(`NIE_SET_OFFSET, 32'hFFFF_0000, 4'hC);
		chk(rsp, `NIE_RESP_OKAY);
		chk(irq_enable, 32'h4FF);
		prot_lock_in <= 0;
		@(posedge aclk);
		wr(`NIE_SET_OFFSET, 32'hFFFF_0000, 4'h8);
		chk(irq_enable, 32'h7FF);
		rd(`NIE_SET_OFFSET);
		chk(rd_data[31:16], `NIE_SET_MASK);
	endtask
	task t_clear;
		wr(`NIE_CLR_OFFSET, 32'h0000_0001, 4'h1);
		chk(irq_enable, 32'h7FE);
		@(posedge aclk);
		chk(irq, 1'h0);
		rd(`NIE_CLR_OFFSET);
		chk(rd_data[15:0], 32'h7FE);
	endtask
	task t_bad;
		rd(8'h20);
		chk(rsp, `NIE_RESP_SLVERR);
		chk(rd_data, 32'h0);
	endtask
	task tally_and_finish;
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge aclk);
		n_fail++;
		tally_and_finish;
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_reset;
		t_set;
		t_prot;
		t_clear;
		t_bad;
		tally_and_finish;
	end
endmodule
`default_nettype wire
